// ### rtl/fdom_pkg.sv
// Constants for the fast-detect and overrange monitor.
// Assumes a register port fed by the device's serial-port controller.
package fdom_pkg;

	// -------------------------------------------------------------------------
	// Register map.
	// -------------------------------------------------------------------------
	localparam logic [11:0] FDOM_ADDR_PIN_FUNC   = 12'h040;
	localparam logic [11:0] FDOM_ADDR_UPPER_LO   = 12'h247;
	localparam logic [11:0] FDOM_ADDR_UPPER_HI   = 12'h248;
	localparam logic [11:0] FDOM_ADDR_LOWER_LO   = 12'h249;
	localparam logic [11:0] FDOM_ADDR_LOWER_HI   = 12'h24A;
	localparam logic [11:0] FDOM_ADDR_DWELL_LO   = 12'h24B;
	localparam logic [11:0] FDOM_ADDR_DWELL_HI   = 12'h24C;
	localparam logic [11:0] FDOM_ADDR_OVR_CLEAR  = 12'h562;
	localparam logic [11:0] FDOM_ADDR_OVR_STATUS = 12'h563;

	// -------------------------------------------------------------------------
	// Widths and field layout.
	// -------------------------------------------------------------------------
	localparam int FDOM_ADDR_W      = 12;
	localparam int FDOM_SAMPLE_W    = 14;
	localparam int FDOM_MAG_W       = 14;
	localparam int FDOM_THRESH_W    = 13;
	localparam int FDOM_THRESH_HI_W = 5;
	localparam int FDOM_DWELL_W     = 16;
	localparam int FDOM_NUM_CHAN    = 2;
	localparam int FDOM_NUM_VCONV   = 8;
	localparam int FDOM_PIN_FUNC_W  = 3;
	localparam int FDOM_CTRL_CNT_W  = 2;

	// -------------------------------------------------------------------------
	// Reset values.
	// -------------------------------------------------------------------------
	localparam logic [7:0] FDOM_RST_PIN_FUNC = 8'h00;
	localparam logic [7:0] FDOM_RST_UPPER_LO = 8'h00;
	localparam logic [7:0] FDOM_RST_UPPER_HI = 8'h00;
	localparam logic [7:0] FDOM_RST_LOWER_LO = 8'h00;
	localparam logic [7:0] FDOM_RST_LOWER_HI = 8'h00;
	localparam logic [7:0] FDOM_RST_DWELL_LO = 8'h01;
	localparam logic [7:0] FDOM_RST_DWELL_HI = 8'h00;
	localparam logic [7:0] FDOM_RST_CLEAR    = 8'h00;

	// -------------------------------------------------------------------------
	// Functions that the first detect pin can carry.
	// -------------------------------------------------------------------------
	localparam logic [2:0] FDOM_PIN_FAST_DETECT = 3'h0;
	localparam logic [2:0] FDOM_PIN_OVERRANGE   = 3'h1;
	localparam logic [2:0] FDOM_PIN_TEMP_DIODE  = 3'h2;
	localparam logic [2:0] FDOM_PIN_DRIVE_HIGH  = 3'h3;

	// Upper-threshold assertion must not exceed this many sample clocks.
	localparam int FDOM_UPPER_LATENCY_MAX = 28;

endpackage : fdom_pkg

// ### rtl/fdom_top.sv
// Fast threshold detect and overrange monitor for both converter channels.
// Assumes samples arrive one per clk_i from the converter cores, and that the
// serial-port controller presents register reads and writes on this clock.
//
// Behaviour
// - Overrange indication per channel, aligned to its own sample.
// - With nonzero control bits, overrange rides as a control bit per sample.
// - Eight sticky overrange bits, one per virtual converter, readable.
// - Writing clear bit one then zero clears that sticky bit.
// - Detect flag sets once magnitude exceeds the upper threshold.
// - Detect flag clears only after magnitude stays below lower for over dwell.
// - Upper threshold held in two registers, compared with output magnitude.
// - Upper-threshold detect asserts within 28 sample clocks.
// - Lower threshold is 13 bits over two registers, full resolution.
// - Lower comparison uses pipelined output samples, not an estimate.
// - Thresholds are magnitudes against a full scale of two to thirteen.
// - Dwell time programmable 1 to 65535 cycles in two registers.
// - Each channel has independent detect logic and its own pin.
// - A three-bit field selects the first detect pin's function.
`timescale 1ns/10ps

module fdom_top (
	input  wire logic                                clk_i,
	input  wire logic                                rst_i,
	input  wire logic [fdom_pkg::FDOM_SAMPLE_W-1:0]  sample_a_i,
	input  wire logic [fdom_pkg::FDOM_SAMPLE_W-1:0]  sample_b_i,
	input  wire logic                                overrange_a_i,
	input  wire logic                                overrange_b_i,
	input  wire logic [fdom_pkg::FDOM_NUM_VCONV-1:0] vconv_overrange_i,
	input  wire logic [fdom_pkg::FDOM_CTRL_CNT_W-1:0] ctrl_bits_i,
	input  wire logic                                reg_wr_i,
	input  wire logic                                reg_rd_i,
	input  wire logic [fdom_pkg::FDOM_ADDR_W-1:0]    reg_addr_i,
	input  wire logic [7:0]                          reg_wdata_i,
	output logic      [7:0]                          reg_rdata_o,
	output logic      [fdom_pkg::FDOM_SAMPLE_W-1:0]  sample_a_o,
	output logic      [fdom_pkg::FDOM_SAMPLE_W-1:0]  sample_b_o,
	output logic                                     ctrl_a_o,
	output logic                                     ctrl_b_o,
	output logic                                     detect_out_chan_a_o,
	output logic                                     detect_out_chan_b_o,
	output logic                                     temp_diode_route_o
);
	import fdom_pkg::*;

	// -------------------------------------------------------------------------
	// Configuration registers.
	// -------------------------------------------------------------------------
	logic [7:0] pin_func_reg;
	logic [7:0] upper_lo_reg;
	logic [7:0] upper_hi_reg;
	logic [7:0] lower_lo_reg;
	logic [7:0] lower_hi_reg;
	logic [7:0] dwell_lo_reg;
	logic [7:0] dwell_hi_reg;
	logic [7:0] ovr_clear_reg;
	logic [7:0] ovr_status_reg;
	logic [7:0] ovr_status_next;

	wire wr_pin_func  = reg_wr_i && (reg_addr_i == FDOM_ADDR_PIN_FUNC);
	wire wr_upper_lo  = reg_wr_i && (reg_addr_i == FDOM_ADDR_UPPER_LO);
	wire wr_upper_hi  = reg_wr_i && (reg_addr_i == FDOM_ADDR_UPPER_HI);
	wire wr_lower_lo  = reg_wr_i && (reg_addr_i == FDOM_ADDR_LOWER_LO);
	wire wr_lower_hi  = reg_wr_i && (reg_addr_i == FDOM_ADDR_LOWER_HI);
	wire wr_dwell_lo  = reg_wr_i && (reg_addr_i == FDOM_ADDR_DWELL_LO);
	wire wr_dwell_hi  = reg_wr_i && (reg_addr_i == FDOM_ADDR_DWELL_HI);
	wire wr_ovr_clear = reg_wr_i && (reg_addr_i == FDOM_ADDR_OVR_CLEAR);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pin_func_reg  <= FDOM_RST_PIN_FUNC;
			upper_lo_reg  <= FDOM_RST_UPPER_LO;
			upper_hi_reg  <= FDOM_RST_UPPER_HI;
			lower_lo_reg  <= FDOM_RST_LOWER_LO;
			lower_hi_reg  <= FDOM_RST_LOWER_HI;
			dwell_lo_reg  <= FDOM_RST_DWELL_LO;
			dwell_hi_reg  <= FDOM_RST_DWELL_HI;
			ovr_clear_reg <= FDOM_RST_CLEAR;
		end else begin
			if (wr_pin_func) begin
				pin_func_reg <= reg_wdata_i;
			end
			if (wr_upper_lo) begin
				upper_lo_reg <= reg_wdata_i;
			end
			if (wr_upper_hi) begin
				upper_hi_reg <= reg_wdata_i;
			end
			if (wr_lower_lo) begin
				lower_lo_reg <= reg_wdata_i;
			end
			if (wr_lower_hi) begin
				lower_hi_reg <= reg_wdata_i;
			end
			if (wr_dwell_lo) begin
				dwell_lo_reg <= reg_wdata_i;
			end
			if (wr_dwell_hi) begin
				dwell_hi_reg <= reg_wdata_i;
			end
			if (wr_ovr_clear) begin
				ovr_clear_reg <= reg_wdata_i;
			end
		end
	end

	// Thresholds are 13-bit magnitudes on a 2^13 full scale; the high register
	// contributes only its low five bits.
	wire [FDOM_THRESH_W-1:0] upper_thresh = {upper_hi_reg[FDOM_THRESH_HI_W-1:0], upper_lo_reg};
	wire [FDOM_THRESH_W-1:0] lower_thresh = {lower_hi_reg[FDOM_THRESH_HI_W-1:0], lower_lo_reg};
	wire [FDOM_DWELL_W-1:0]  dwell_time   = {dwell_hi_reg, dwell_lo_reg};
	wire [FDOM_PIN_FUNC_W-1:0] pin_func   = pin_func_reg[FDOM_PIN_FUNC_W-1:0];

	// -------------------------------------------------------------------------
	// Sticky overrange status per virtual converter.
	// -------------------------------------------------------------------------
	// A set in the same cycle as a held clear wins, but the held clear wipes that bit on the next cycle.
	always_comb begin
		ovr_status_next = (ovr_status_reg & ~ovr_clear_reg) | vconv_overrange_i;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ovr_status_reg <= 8'h00;
		end else begin
			ovr_status_reg <= ovr_status_next;
		end
	end

	// -------------------------------------------------------------------------
	// Register read path.
	// -------------------------------------------------------------------------
	logic [7:0] rd_mux;

	always_comb begin
		case (reg_addr_i)
			FDOM_ADDR_PIN_FUNC:   rd_mux = pin_func_reg;
			FDOM_ADDR_UPPER_LO:   rd_mux = upper_lo_reg;
			FDOM_ADDR_UPPER_HI:   rd_mux = upper_hi_reg;
			FDOM_ADDR_LOWER_LO:   rd_mux = lower_lo_reg;
			FDOM_ADDR_LOWER_HI:   rd_mux = lower_hi_reg;
			FDOM_ADDR_DWELL_LO:   rd_mux = dwell_lo_reg;
			FDOM_ADDR_DWELL_HI:   rd_mux = dwell_hi_reg;
			FDOM_ADDR_OVR_CLEAR:  rd_mux = ovr_clear_reg;
			FDOM_ADDR_OVR_STATUS: rd_mux = ovr_status_reg;
			default:              rd_mux = 8'h00;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			reg_rdata_o <= 8'h00;
		end else if (reg_rd_i) begin
			reg_rdata_o <= rd_mux;
		end
	end

	// -------------------------------------------------------------------------
	// Per-channel sample path and fast detect.
	// -------------------------------------------------------------------------
	wire [FDOM_SAMPLE_W-1:0] sample_in [FDOM_NUM_CHAN];
	wire                     ovr_in    [FDOM_NUM_CHAN];
	logic [FDOM_SAMPLE_W-1:0] sample_out [FDOM_NUM_CHAN];
	logic                     ctrl_out   [FDOM_NUM_CHAN];
	logic                     flag_out   [FDOM_NUM_CHAN];
	logic                     ovr_out    [FDOM_NUM_CHAN];

	assign sample_in[0] = sample_a_i;
	assign sample_in[1] = sample_b_i;
	assign ovr_in[0]    = overrange_a_i;
	assign ovr_in[1]    = overrange_b_i;

	wire ctrl_enabled = (ctrl_bits_i != '0);

	for (genvar ch = 0; ch < FDOM_NUM_CHAN; ch++) begin : g_chan
		logic [FDOM_SAMPLE_W-1:0] sample_reg;
		logic                     ovr_reg;
		logic [FDOM_MAG_W-1:0]    mag_reg;
		logic                     flag_reg;
		logic                     flag_next;
		logic [FDOM_DWELL_W-1:0]  dwell_cnt_reg;
		logic [FDOM_DWELL_W-1:0]  dwell_cnt_next;

		// Two's complement magnitude; the most negative code gives 2^13.
		wire [FDOM_MAG_W-1:0] mag_abs = sample_in[ch][FDOM_SAMPLE_W-1] ?
			FDOM_MAG_W'(~sample_in[ch] + 1'b1) : sample_in[ch];
		wire above_upper = mag_reg > {1'b0, upper_thresh};
		wire below_lower = mag_reg < {1'b0, lower_thresh};
		wire dwell_done  = dwell_cnt_reg >= dwell_time;

		always_comb begin
			flag_next      = flag_reg;
			dwell_cnt_next = '0;
			if (above_upper) begin
				flag_next = 1'b1;
			end else if (flag_reg && below_lower) begin
				if (dwell_done) begin
					flag_next = 1'b0;
				end else begin
					dwell_cnt_next = dwell_cnt_reg + 1'b1;
				end
			end
			// Any sample at or above the lower threshold leaves the count at zero.
		end

		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				sample_reg    <= '0;
				ovr_reg       <= 1'b0;
				mag_reg       <= '0;
				flag_reg      <= 1'b0;
				dwell_cnt_reg <= '0;
			end else begin
				sample_reg    <= sample_in[ch];
				ovr_reg       <= ovr_in[ch];
				mag_reg       <= mag_abs;
				flag_reg      <= flag_next;
				dwell_cnt_reg <= dwell_cnt_next;
			end
		end

		assign sample_out[ch] = sample_reg;
		assign ctrl_out[ch]   = ctrl_enabled & ovr_reg;
		assign ovr_out[ch]    = ovr_reg;
		assign flag_out[ch]   = flag_reg;
	end

	assign sample_a_o = sample_out[0];
	assign sample_b_o = sample_out[1];
	assign ctrl_a_o   = ctrl_out[0];
	assign ctrl_b_o   = ctrl_out[1];

	// -------------------------------------------------------------------------
	// Detect pin function selection.
	// -------------------------------------------------------------------------
	logic pin_a_sel;

	always_comb begin
		case (pin_func)
			FDOM_PIN_FAST_DETECT: pin_a_sel = flag_out[0];
			FDOM_PIN_OVERRANGE:   pin_a_sel = ovr_out[0];
			FDOM_PIN_DRIVE_HIGH:  pin_a_sel = 1'b1;
			default:              pin_a_sel = 1'b0;
		endcase
	end

	// The pin is released to the diode when routed, so it drives low then.
	assign detect_out_chan_a_o = pin_a_sel;
	assign detect_out_chan_b_o = flag_out[1];
	assign temp_diode_route_o  = (pin_func == FDOM_PIN_TEMP_DIODE);

endmodule : fdom_top

// ### tb/fdom_host.sv
// Register host model that drives the monitor's register port.
// Assumes calls start from the falling edge of clk_i, one at a time.
`timescale 1ns/10ps
module fdom_host (
	input  wire logic        clk_i,
	input  wire logic [7:0]  rdata_i,
	output logic             wr_o,
	output logic             rd_o,
	output logic      [11:0] addr_o,
	output logic      [7:0]  wdata_o
);
	initial begin
		{wr_o, rd_o, addr_o, wdata_o} = 22'h0;
	end
	// Idle address and data are inverted so stale values never look valid.
	task automatic wr(input logic [11:0] a, input logic [7:0] v);
		@(negedge clk_i);
		{wr_o, addr_o, wdata_o} = {1'b1, a, v};
		@(negedge clk_i);
		{wr_o, addr_o, wdata_o} = {1'b0, ~a, ~v};
	endtask : wr
	task automatic rd(input logic [11:0] a, output logic [7:0] v);
		@(negedge clk_i);
		{rd_o, addr_o} = {1'b1, a};
		@(negedge clk_i);
		{rd_o, addr_o} = {1'b0, ~a};
		v = rdata_i;
	endtask : rd
	task automatic clr(input logic [7:0] m);
		wr(12'h562, m);
		wr(12'h562, 8'h00);
	endtask : clr
endmodule : fdom_host

// ### tb/fdom_monitor.sv
// Port checker for fdom_top.
// Assumes it is bound into fdom_top and sees only its ports.
`timescale 1ns/10ps
module fdom_monitor (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic [13:0] sample_b_i,
	input wire logic        overrange_a_i,
	input wire logic [1:0]  ctrl_bits_i,
	input wire logic        reg_wr_i,
	input wire logic        reg_rd_i,
	input wire logic [11:0] reg_addr_i,
	input wire logic [7:0]  reg_wdata_i,
	input wire logic [7:0]  reg_rdata_o,
	input wire logic        ctrl_a_o,
	input wire logic        detect_out_chan_a_o,
	input wire logic        detect_out_chan_b_o,
	input wire logic        temp_diode_route_o
);
	logic [12:0] up_q;
	logic [12:0] lo_q;
	logic [2:0]  fs_q;
	logic [13:0] mag;
	logic        below;
	assign mag = sample_b_i[13] ? 14'(-sample_b_i) : sample_b_i;
	assign below = mag < {1'b0, lo_q};
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			{up_q, lo_q, fs_q} <= 29'h0;
		end else if (reg_wr_i) begin
			case (reg_addr_i)
				12'h040: fs_q <= reg_wdata_i[2:0];
				12'h247: up_q[7:0] <= reg_wdata_i;
				12'h248: up_q[12:8] <= reg_wdata_i[4:0];
				12'h249: lo_q[7:0] <= reg_wdata_i;
				12'h24A: lo_q[12:8] <= reg_wdata_i[4:0];
				default: ;
			endcase
		end
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	property p_ctrl; !$past(rst_i) |-> ctrl_a_o == ($past(overrange_a_i) && ctrl_bits_i != 2'h0);
	endproperty
	a_ctrl: assert property (p_ctrl) else $error("ctrl bit wrong");
	property p_rise; mag > {1'b0, up_q} |-> ##[1:2] detect_out_chan_b_o; endproperty
	a_rise: assert property (p_rise) else $error("detect late");
	property p_fall; $fell(detect_out_chan_b_o) |-> $past(below, 2) && $past(below, 3); endproperty
	a_fall: assert property (p_fall) else $error("detect cleared early");
	property p_hold; !below ##1 detect_out_chan_b_o |=> detect_out_chan_b_o; endproperty
	a_hold: assert property (p_hold) else $error("dwell not restarted");
	property p_diode; temp_diode_route_o == (fs_q == 3'h2); endproperty
	a_diode: assert property (p_diode) else $error("diode route wrong");
	property p_pinhi; fs_q == 3'h3 |-> detect_out_chan_a_o; endproperty
	a_pinhi: assert property (p_pinhi) else $error("pin a not high");
	property p_pinoff; fs_q == 3'h2 || fs_q > 3'h3 |-> !detect_out_chan_a_o; endproperty
	a_pinoff: assert property (p_pinoff) else $error("pin a not low");
	property p_rdfs; reg_rd_i && reg_addr_i == 12'h040 |=> reg_rdata_o[2:0] == fs_q; endproperty
	a_rdfs: assert property (p_rdfs) else $error("pin select readback");
endmodule : fdom_monitor
bind fdom_top fdom_monitor u_mon (.clk_i, .rst_i, .sample_b_i, .overrange_a_i, .ctrl_bits_i,
	.reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .ctrl_a_o,
	.detect_out_chan_a_o, .detect_out_chan_b_o, .temp_diode_route_o);

// ### tb/fast_detect_overrange_monitor_tb_top.sv
// Self-checking bench for fdom_top.
// Assumes fdom_host and the bound checker are compiled alongside.
`timescale 1ns/10ps
module fast_detect_overrange_monitor_tb_top;
	logic        clk_i, rst_i, ovr_a, ovr_b, wr, rd, ca, cb, det_a, det_b, dio;
	logic [13:0] s_a, s_b, sa_o, sb_o;
	logic [7:0]  vc, rdata, wdata, d;
	logic [11:0] addr;
	logic [1:0]  nctl;
	int          num_errors, n_checks, n;
	fdom_top DUT (.clk_i(clk_i), .rst_i(rst_i), .sample_a_i(s_a), .sample_b_i(s_b),
		.overrange_a_i(ovr_a), .overrange_b_i(ovr_b), .vconv_overrange_i(vc),
		.ctrl_bits_i(nctl), .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr),
		.reg_wdata_i(wdata), .reg_rdata_o(rdata), .sample_a_o(sa_o), .sample_b_o(sb_o),
		.ctrl_a_o(ca), .ctrl_b_o(cb), .detect_out_chan_a_o(det_a),
		.detect_out_chan_b_o(det_b), .temp_diode_route_o(dio));
	fdom_host u_host (.clk_i(clk_i), .rdata_i(rdata), .wr_o(wr), .rd_o(rd), .addr_o(addr),
		.wdata_o(wdata));
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_checks++;
		if (e !== g) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic results();
		$display("Checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : results
	// Counts clock cycles until the channel B flag reaches v, with a bound.
	task automatic wait_b(input logic v);
		n = 0;
		while (det_b !== v && n < 40) begin
			@(negedge clk_i);
			n++;
		end
		if (n >= 40) begin
			num_errors++;
			results();
		end
	endtask : wait_b
	task automatic t_regs();
		u_host.rd(12'h24B, d);
		chk("dwell_lo reset", 8'h01, d);
		u_host.wr(12'h248, 8'hFF);
		u_host.rd(12'h248, d);
		chk("upper_hi", 8'hFF, d);
		u_host.wr(12'h123, 8'h5A);
		u_host.rd(12'h123, d);
		chk("unmapped", 8'h00, d);
	endtask : t_regs
	task automatic t_detect();
		u_host.wr(12'h247, 8'h64);
		u_host.wr(12'h248, 8'h00);
		u_host.wr(12'h249, 8'h32);
		u_host.wr(12'h24A, 8'h00);
		u_host.wr(12'h24B, 8'h03);
		u_host.wr(12'h24C, 8'h00);
		s_b = 14'h3F9B;
		wait_b(1'b1);
		chk("rise cycles", 16'd2, 16'(n));
		chk("pin a quiet", 16'd0, 16'(det_a));
		s_b = 14'd20;
		repeat (3) @(negedge clk_i);
		s_b = 14'd60;
		@(negedge clk_i);
		s_b = 14'd20;
		wait_b(1'b0);
		chk("fall cycles", 16'd5, 16'(n));
	endtask : t_detect
	task automatic t_ovr();
		{nctl, ovr_a} = 3'b011;
		@(negedge clk_i);
		ovr_a = 1'b0;
		chk("ctrl_a", 16'd1, 16'(ca));
		chk("ctrl_b", 16'd0, 16'(cb));
		{nctl, ovr_b} = 3'b001;
		@(negedge clk_i);
		ovr_b = 1'b0;
		chk("ctrl_b off", 16'd0, 16'(cb));
	endtask : t_ovr
	task automatic t_sticky();
		vc = 8'h81;
		@(negedge clk_i);
		vc = 8'h00;
		u_host.wr(12'h563, 8'h00);
		u_host.rd(12'h563, d);
		chk("sticky", 8'h81, d);
		u_host.clr(8'h80);
		u_host.rd(12'h563, d);
		chk("cleared", 8'h01, d);
		u_host.wr(12'h562, 8'h01);
		vc = 8'h01;
		u_host.rd(12'h563, d);
		vc = 8'h00;
		chk("set wins", 8'h01, d);
		u_host.wr(12'h562, 8'h00);
		u_host.rd(12'h563, d);
		chk("clear held", 8'h00, d);
	endtask : t_sticky
	task automatic t_chan_a();
		u_host.wr(12'h040, 8'h00);
		s_a = 14'd101;
		repeat (2) @(negedge clk_i);
		chk("pin a detect", 16'd1, 16'(det_a));
		chk("pin b idle", 16'd0, 16'(det_b));
		s_a = 14'd0;
		u_host.wr(12'h040, 8'h01);
		chk("pin a no ovr", 16'd0, 16'(det_a));
		{nctl, ovr_a, ovr_b, s_a, s_b} = {2'b10, 2'b11, 14'h0ABC, 14'd30};
		@(negedge clk_i);
		{ovr_a, ovr_b} = 2'b00;
		chk("pin a ovr", 16'd1, 16'(det_a));
		chk("sample a", 16'h0ABC, 16'(sa_o));
		chk("ctrl_a aligned", 16'd1, 16'(ca));
		chk("sample b", 16'd30, 16'(sb_o));
		chk("ctrl_b aligned", 16'd1, 16'(cb));
		nctl = 2'b00;
	endtask : t_chan_a
	task automatic t_pin();
		for (int c = 0; c < 8; c++) begin
			u_host.wr(12'h040, 8'(c));
			u_host.rd(12'h040, d);
			chk("pin select", 16'(c), 16'(d));
			chk("diode", 16'(c == 2), 16'(dio));
			chk("pin a", 16'(c == 3), 16'(det_a));
		end
	endtask : t_pin
	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end
	initial begin
		rst_i = 1'b1;
		{ovr_a, ovr_b, nctl, vc, s_a, s_b} = 40'h0;
		{num_errors, n_checks} = 64'h0;
		repeat (4) @(negedge clk_i);
		rst_i = 1'b0;
		t_regs();
		t_detect();
		t_ovr();
		t_sticky();
		t_pin();
		t_chan_a();
		results();
	end
endmodule : fast_detect_overrange_monitor_tb_top
